// >>> design/inv_link_pkg.sv
// Constants and carriers shared by the remote command word decoder.
// Assumes link words, request bits and core answers share one clock.
package inv_link_pkg;
    localparam int WORD_W        = 16;
    localparam int CODE_W        = 8;
    localparam int MON_ITEMS     = 6;
    localparam int EXT_LSB       = 8;
    localparam int EEPROM_CYCLES = 16;

    localparam logic [15:0] EXT_STD_A  = 16'h0000;
    localparam logic [15:0] EXT_STD_B  = 16'h0001;
    localparam logic [15:0] EXT_STD_C  = 16'h000c;
    localparam logic [7:0]  TSRC_A     = 8'h03;
    localparam logic [7:0]  TSRC_B     = 8'h05;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0]  CODE_RESET = 8'h00;

    // Master-to-device cyclic words; mon_ef carries monitor codes 5 and 6
    typedef struct packed {
        logic [WORD_W-1:0] mon_ef;
        logic [WORD_W-1:0] mon_d;
        logic [WORD_W-1:0] mon_c;
        logic [WORD_W-1:0] instr_data;
        logic [WORD_W-1:0] instr_code;
        logic [WORD_W-1:0] freq_or_torque;
        logic [WORD_W-1:0] mon_a;
    } link_cmd_s;

    typedef struct packed {
        logic monitor;
        logic volatile_wr;
        logic persistent_wr;
        logic instr_exec;
    } link_req_s;

    typedef struct packed {
        logic monitoring;
        logic volatile_done;
        logic persistent_done;
        logic instr_done;
    } link_flag_s;

    // Entry 0,1 are result words 0,1; entries 2..5 are result words 4..7
    typedef logic [MON_ITEMS-1:0][WORD_W-1:0] mon_words_t;
    typedef logic [MON_ITEMS-1:0][CODE_W-1:0] mon_codes_t;
endpackage

// >>> design/inv_monitor_capture.sv
// Walks the six monitor codes and captures one core value per code.
// Assumes the core answers value_i combinationally for code_o.
`timescale 1ns/1ps
module inv_monitor_capture (
    input  wire logic                              clock_i,
    input  wire logic                              nrst_i,
    input  wire logic                              start_i,
    input  wire inv_link_pkg::mon_codes_t          codes_i,
    input  wire logic [inv_link_pkg::WORD_W-1:0]   value_i,
    output logic      [inv_link_pkg::CODE_W-1:0]   code_o,
    output logic                                   busy_o,
    output logic                                   done_o,
    output inv_link_pkg::mon_words_t               results_o
);
    typedef struct packed {
        logic                            busy;
        logic                            done;
        logic [2:0]                      idx;
        logic [inv_link_pkg::CODE_W-1:0] code;
        inv_link_pkg::mon_words_t        res;
    } cap_state_s;

    cap_state_s s;
    cap_state_s next_s;

    // Codes are read live; the master must hold them during a walk
    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        if (s.busy)
        begin
            next_s.res[s.idx] = value_i; // see (R13)
            if (s.idx == 3'(inv_link_pkg::MON_ITEMS - 1))
            begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
            else
            begin
                next_s.idx  = s.idx + 3'h1;
                next_s.code = codes_i[s.idx + 3'h1];
            end
        end
        else if (start_i)
        begin
            next_s.busy = 1'b1;
            next_s.idx  = 3'h0;
            next_s.code = codes_i[0]; // see (R12)
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign code_o    = s.code;
    assign busy_o    = s.busy;
    assign done_o    = s.done;
    assign results_o = s.res;

    property p_walk_len;
        @(posedge clock_i) disable iff (!nrst_i)
        (start_i && !s.busy) |-> ##7 done_o;
    endproperty
    a_walk_len: assert property (p_walk_len) else $error("capture walk length wrong"); // see (R12)

    property p_first_item;
        @(posedge clock_i) disable iff (!nrst_i)
        done_o |-> (results_o[0] == $past(value_i, 6)) && (results_o[5] == $past(value_i));
    endproperty
    a_first_item: assert property (p_first_item) else $error("monitor item misplaced"); // see (R1)
endmodule

// >>> design/inv_write_engine.sv
// Stores the frequency or torque word in RAM and, if asked, EEPROM copies.
// Assumes the EEPROM commit takes a fixed number of core cycles.
`timescale 1ns/1ps
module inv_write_engine #(
    parameter int EE_CYCLES = inv_link_pkg::EEPROM_CYCLES
) (
    input  wire logic                            clock_i,
    input  wire logic                            nrst_i,
    input  wire logic                            start_i,
    input  wire logic                            persist_i,
    input  wire logic                            torque_mode_i,
    input  wire logic [inv_link_pkg::WORD_W-1:0] value_i,
    output logic                                 done_o,
    output logic      [inv_link_pkg::WORD_W-1:0] freq_ram_o,
    output logic      [inv_link_pkg::WORD_W-1:0] freq_eeprom_o,
    output logic      [inv_link_pkg::WORD_W-1:0] torque_vol_o,
    output logic      [inv_link_pkg::WORD_W-1:0] torque_per_o
);
    typedef struct packed {
        logic        busy;
        logic        done;
        logic        torque;
        logic [15:0] value;
        logic [15:0] cnt;
        logic [15:0] f_ram;
        logic [15:0] f_ee;
        logic [15:0] t_vol;
        logic [15:0] t_per;
    } wr_state_s;

    wr_state_s s;
    wr_state_s next_s;

    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        if (s.busy)
        begin
            if (s.cnt == 16'(EE_CYCLES - 1))
            begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
                if (s.torque)
                    next_s.t_per = s.value; // see (R6)
                else
                    next_s.f_ee = s.value;
            end
            else
                next_s.cnt = s.cnt + 16'h0001;
        end
        else if (start_i)
        begin
            next_s.torque = torque_mode_i;
            next_s.value  = value_i;
            next_s.cnt    = 16'h0000;
            // RAM copy is written at once, also ahead of an EEPROM commit
            if (torque_mode_i)
                next_s.t_vol = value_i; // see (R6)
            else
                next_s.f_ram = value_i;
            if (persist_i)
                next_s.busy = 1'b1; // see (R3)
            else
                next_s.done = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign done_o        = s.done;
    assign freq_ram_o    = s.f_ram;
    assign freq_eeprom_o = s.f_ee;
    assign torque_vol_o  = s.t_vol;
    assign torque_per_o  = s.t_per;

    property p_ee_wait;
        @(posedge clock_i) disable iff (!nrst_i)
        (start_i && persist_i && !s.busy) |=> !done_o ##[1:1000] done_o;
    endproperty
    a_ee_wait: assert property (p_ee_wait) else $error("EEPROM write never finished"); // see (R3)
endmodule

// >>> design/inv_remote_command.sv
// Top of the remote command word decoder: requests, flags and writes.
// Assumes the fieldbus master logic shares clock_i and keeps the
// request/completion handshake; core answers arrive on the same clock.
`timescale 1ns/1ps
// Functional notes
// (R1) Monitor request captures items of codes 1 and 2 into result words 0, 1.
// (R2) Master gives set frequency in 0.01 Hz counts, 0 to 59000.
// (R3) Volatile request writes RAM only; persistent request writes RAM and EEPROM.
// (R4) Finished write sets the completion flag matching the request used.
// (R5) Word 1 is torque only for extension 0, 1, 12 and source 3 or 5.
// (R6) Torque write also updates stored torque values for RAM and EEPROM copies.
// (R7) Master loads instruction code and data before raising the execution request.
// (R8) Instruction-complete flag rises only after the instruction has executed.
// (R9) Nonzero extension setting: upper 8 bits of code are the extended setting.
// (R10) Master places the instruction's operand in write data before requesting.
// (R11) Master zeroes write data when the instruction needs none.
// (R12) Master loads codes 3, 4 then requests; device captures those items.
// (R13) Additional monitor codes return in result words four through seven.
// (R14) Monitoring flag rises after capture, drops when the request clears.
// (R15) Each completion flag rises after its work, drops with its request.
// (R16) Master holds a request until its flag, then waits for the flag to drop.
module inv_remote_command #(
    parameter int EE_CYCLES = inv_link_pkg::EEPROM_CYCLES
) (
    input  wire logic                            clock_i,
    input  wire logic                            nrst_i,
    input  wire inv_link_pkg::link_cmd_s         cmd_i,
    input  wire inv_link_pkg::link_req_s         req_i,
    input  wire logic [inv_link_pkg::WORD_W-1:0] link_extension_setting_i,
    input  wire logic [inv_link_pkg::CODE_W-1:0] torque_source_select_i,
    input  wire logic [inv_link_pkg::WORD_W-1:0] monitor_value_i,
    input  wire logic                            instr_ack_i,
    output inv_link_pkg::link_flag_s             flags_o,
    output inv_link_pkg::mon_words_t             monitor_result_o,
    output logic      [inv_link_pkg::CODE_W-1:0] monitor_code_o,
    output logic      [inv_link_pkg::WORD_W-1:0] set_freq_ram_o,
    output logic      [inv_link_pkg::WORD_W-1:0] set_freq_eeprom_o,
    output logic      [inv_link_pkg::WORD_W-1:0] torque_value_volatile_o,
    output logic      [inv_link_pkg::WORD_W-1:0] torque_value_persistent_o,
    output logic                                 instr_start_o,
    output logic      [inv_link_pkg::WORD_W-1:0] instr_code_o,
    output logic      [inv_link_pkg::WORD_W-1:0] instr_data_o,
    output logic      [inv_link_pkg::CODE_W-1:0] link_ext_param_o
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WRITE,
        ST_INSTR
    } main_e;

    typedef struct packed {
        main_e                           st;
        inv_link_pkg::link_flag_s        flags;
        logic                            cap_go;
        logic                            wr_go;
        logic                            wr_pers;
        logic                            wr_torque;
        logic                            start;
        logic [inv_link_pkg::WORD_W-1:0] code;
        logic [inv_link_pkg::WORD_W-1:0] data;
        logic [inv_link_pkg::CODE_W-1:0] ext;
    } top_state_s;

    top_state_s                s;
    top_state_s                next_s;
    logic                      torque_mode;
    logic                      ext_on;
    logic                      in_instr;
    logic                      cap_busy;
    logic                      cap_done;
    logic                      wr_done;
    inv_link_pkg::mon_codes_t  codes;

    // Code 1 low byte, code 2 high byte of the first select word
    assign codes[0] = cmd_i.mon_a[7:0]; // see (R1)
    assign codes[1] = cmd_i.mon_a[15:8];
    assign codes[2] = cmd_i.mon_c[7:0]; // see (R13)
    assign codes[3] = cmd_i.mon_d[7:0];
    assign codes[4] = cmd_i.mon_ef[7:0];
    assign codes[5] = cmd_i.mon_ef[15:8];

    assign torque_mode = ((link_extension_setting_i == inv_link_pkg::EXT_STD_A)
                       || (link_extension_setting_i == inv_link_pkg::EXT_STD_B)
                       || (link_extension_setting_i == inv_link_pkg::EXT_STD_C))
                      && ((torque_source_select_i == inv_link_pkg::TSRC_A)
                       || (torque_source_select_i == inv_link_pkg::TSRC_B)); // see (R5)
    assign ext_on   = (link_extension_setting_i != inv_link_pkg::WORD_RESET);
    assign in_instr = (s.st == ST_INSTR);

    always_comb
    begin
        next_s = s;
        next_s.cap_go = 1'b0;
        next_s.wr_go  = 1'b0;
        next_s.start  = 1'b0;

        // Clears come first so that a same-cycle completion still wins
        if (!req_i.monitor)
            next_s.flags.monitoring = 1'b0; // see (R14)
        if (!req_i.volatile_wr)
            next_s.flags.volatile_done = 1'b0; // see (R15)
        if (!req_i.persistent_wr)
            next_s.flags.persistent_done = 1'b0; // see (R15)
        if (!req_i.instr_exec)
            next_s.flags.instr_done = 1'b0; // see (R15)

        // Capture repeats while the request stays high, keeping values fresh
        if (req_i.monitor && !cap_busy && !s.cap_go)
            next_s.cap_go = 1'b1; // see (R12)
        if (cap_done && req_i.monitor)
            next_s.flags.monitoring = 1'b1; // see (R14)

        case (s.st)
            ST_IDLE:
            begin
                // Word 1 is taken as held by the master during the write
                if (req_i.volatile_wr && !s.flags.volatile_done)
                begin
                    next_s.wr_go     = 1'b1; // see (R3)
                    next_s.wr_pers   = 1'b0;
                    next_s.wr_torque = torque_mode;
                    next_s.st        = ST_WRITE;
                end
                else if (req_i.persistent_wr && !s.flags.persistent_done)
                begin
                    next_s.wr_go     = 1'b1; // see (R3)
                    next_s.wr_pers   = 1'b1;
                    next_s.wr_torque = torque_mode;
                    next_s.st        = ST_WRITE;
                end
                else if (req_i.instr_exec && !s.flags.instr_done)
                begin
                    // Code and data are sampled at the request edge
                    next_s.start = 1'b1; // see (R7)
                    next_s.data  = cmd_i.instr_data; // see (R10)
                    if (ext_on)
                    begin
                        next_s.ext  = cmd_i.instr_code[15:inv_link_pkg::EXT_LSB]; // see (R9)
                        next_s.code = {inv_link_pkg::CODE_RESET,
                                       cmd_i.instr_code[inv_link_pkg::EXT_LSB-1:0]};
                    end
                    else
                    begin
                        next_s.code = cmd_i.instr_code;
                    end
                    next_s.st = ST_INSTR;
                end
            end
            ST_WRITE:
            begin
                if (wr_done)
                begin
                    if (s.wr_pers)
                        next_s.flags.persistent_done = 1'b1; // see (R4)
                    else
                        next_s.flags.volatile_done = 1'b1; // see (R4)
                    next_s.st = ST_IDLE;
                end
            end
            ST_INSTR:
            begin
                if (instr_ack_i)
                begin
                    next_s.flags.instr_done = 1'b1; // see (R8)
                    next_s.st = ST_IDLE;
                end
            end
            default:
            begin
                next_s.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            s <= '0;
        else
            s <= next_s;
    end

    inv_monitor_capture u_capture (
        .clock_i   (clock_i),
        .nrst_i    (nrst_i),
        .start_i   (s.cap_go),
        .codes_i   (codes),
        .value_i   (monitor_value_i),
        .code_o    (monitor_code_o),
        .busy_o    (cap_busy),
        .done_o    (cap_done),
        .results_o (monitor_result_o)
    );

    // The count range is accepted as given; 0..59000 fits the word
    inv_write_engine #(
        .EE_CYCLES (EE_CYCLES)
    ) u_writer (
        .clock_i       (clock_i),
        .nrst_i        (nrst_i),
        .start_i       (s.wr_go),
        .persist_i     (s.wr_pers),
        .torque_mode_i (s.wr_torque),
        .value_i       (cmd_i.freq_or_torque), // see (R2)
        .done_o        (wr_done),
        .freq_ram_o    (set_freq_ram_o),
        .freq_eeprom_o (set_freq_eeprom_o),
        .torque_vol_o  (torque_value_volatile_o),
        .torque_per_o  (torque_value_persistent_o)
    );

    assign flags_o          = s.flags;
    assign instr_start_o    = s.start;
    assign instr_code_o     = s.code;
    assign instr_data_o     = s.data;
    assign link_ext_param_o = s.ext;

    property p_vol_clear;
        @(posedge clock_i) disable iff (!nrst_i)
        (flags_o.volatile_done && !req_i.volatile_wr) |=> !flags_o.volatile_done;
    endproperty
    a_vol_clear: assert property (p_vol_clear) else $error("RAM done flag stuck"); // see (R15)

    property p_pers_clear;
        @(posedge clock_i) disable iff (!nrst_i)
        (flags_o.persistent_done && !req_i.persistent_wr) |=> !flags_o.persistent_done;
    endproperty
    a_pers_clear: assert property (p_pers_clear) else $error("EEPROM done flag stuck"); // see (R15)

    property p_instr_clear;
        @(posedge clock_i) disable iff (!nrst_i)
        (flags_o.instr_done && !req_i.instr_exec) |=> !flags_o.instr_done;
    endproperty
    a_instr_clear: assert property (p_instr_clear) else $error("instr flag stuck"); // see (R15)

    // A second start would run the instruction twice for one request
    property p_start_pulse;
        @(posedge clock_i) disable iff (!nrst_i)
        instr_start_o |=> !instr_start_o;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("instruction started twice"); // see (R8)

    property p_vol_set;
        @(posedge clock_i) disable iff (!nrst_i)
        $rose(flags_o.volatile_done) |-> $past(wr_done) && !$past(s.wr_pers);
    endproperty
    a_vol_set: assert property (p_vol_set) else $error("RAM done flag without write"); // see (R4)

    property p_pers_set;
        @(posedge clock_i) disable iff (!nrst_i)
        $rose(flags_o.persistent_done) |-> $past(wr_done) && $past(s.wr_pers);
    endproperty
    a_pers_set: assert property (p_pers_set) else $error("EEPROM done flag early"); // see (R4)

    property p_instr_done;
        @(posedge clock_i) disable iff (!nrst_i)
        $rose(flags_o.instr_done) |-> $past(instr_ack_i) && $past(in_instr);
    endproperty
    a_instr_done: assert property (p_instr_done) else $error("instruction flag early"); // see (R8)

    property p_ext_split;
        @(posedge clock_i) disable iff (!nrst_i)
        (instr_start_o && $past(ext_on)) |-> (instr_code_o[15:8] == 8'h00)
            && (link_ext_param_o == $past(cmd_i.instr_code[15:8]));
    endproperty
    a_ext_split: assert property (p_ext_split) else $error("extended setting not split"); // see (R9)

    property p_mon_set;
        @(posedge clock_i) disable iff (!nrst_i)
        $rose(flags_o.monitoring) |-> $past(cap_done) && $past(req_i.monitor);
    endproperty
    a_mon_set: assert property (p_mon_set) else $error("monitoring flag without capture"); // see (R14)

    property p_mon_clear;
        @(posedge clock_i) disable iff (!nrst_i)
        (flags_o.monitoring && !req_i.monitor) |=> !flags_o.monitoring;
    endproperty
    a_mon_clear: assert property (p_mon_clear) else $error("monitoring flag stuck"); // see (R14)

    property p_freq_path;
        @(posedge clock_i) disable iff (!nrst_i)
        (s.wr_go && !s.wr_torque) |=> (set_freq_ram_o == $past(cmd_i.freq_or_torque))
            && $stable(torque_value_volatile_o);
    endproperty
    a_freq_path: assert property (p_freq_path) else $error("frequency written as torque"); // see (R5)

    property p_torque_copy;
        @(posedge clock_i) disable iff (!nrst_i)
        ($rose(flags_o.persistent_done) && s.wr_torque)
            |-> torque_value_persistent_o == torque_value_volatile_o;
    endproperty
    a_torque_copy: assert property (p_torque_copy) else $error("torque copies differ"); // see (R6)
endmodule

// >>> dv/fb_master.sv
// Fieldbus master model: loads the cyclic words, then runs one request handshake.
// Assumes it shares clock_i with the decoder and that the flags are registered.
`timescale 1ns/1ps
module fb_master (
    input  wire inv_link_pkg::link_flag_s clock_flags_i,
    input  wire logic                     clock_i,
    output inv_link_pkg::link_cmd_s       cmd_o,
    output inv_link_pkg::link_req_s       req_o
);
    initial
    begin
        cmd_o = '0;
        req_o = '0;
    end

    // Words go out one edge ahead of the request bit and stay put meanwhile
    task automatic request(input int idx, input inv_link_pkg::link_cmd_s words,
                           output int lat, output logic ok);
        int n;
        @(posedge clock_i);
        cmd_o <= words;
        @(posedge clock_i);
        req_o[idx] <= 1'b1;
        lat = 0;
        while (clock_flags_i[idx] !== 1'b1 && lat < 200)
        begin
            @(posedge clock_i);
            lat++;
        end
        ok = (clock_flags_i[idx] === 1'b1);
        req_o[idx] <= 1'b0;
        n = 0;
        while (clock_flags_i[idx] !== 1'b0 && n < 20)
        begin
            @(posedge clock_i);
            n++;
        end
        ok = ok && (clock_flags_i[idx] === 1'b0);
    endtask
endmodule

// >>> dv/tb.sv
// Self-checking bench for the remote command word decoder.
// Assumes fb_master drives words and requests; the core side is modelled here.
`timescale 1ns/1ps
module tb;
    localparam int EE = 2;
    logic                       clock_i;
    logic                       nrst_i;
    logic                       ack;
    logic [15:0]                ext;
    logic [7:0]                 tsrc;
    logic [15:0]                mon_val;
    logic [7:0]                 mon_code;
    logic [7:0]                 ext_par;
    logic                       start;
    logic [15:0]                f_ram;
    logic [15:0]                f_ee;
    logic [15:0]                t_vol;
    logic [15:0]                t_per;
    logic [15:0]                i_code;
    logic [15:0]                i_data;
    inv_link_pkg::link_cmd_s    cmd;
    inv_link_pkg::link_req_s    req;
    inv_link_pkg::link_flag_s   flags;
    inv_link_pkg::mon_words_t   res;
    int                         miscompares;
    int                         num_checks;
    int                         ack_wait;

    inv_remote_command #(.EE_CYCLES(EE)) inv_remote_command_inst (
        .clock_i(clock_i), .nrst_i(nrst_i), .cmd_i(cmd), .req_i(req),
        .link_extension_setting_i(ext), .torque_source_select_i(tsrc),
        .monitor_value_i(mon_val), .instr_ack_i(ack), .flags_o(flags),
        .monitor_result_o(res), .monitor_code_o(mon_code), .set_freq_ram_o(f_ram),
        .set_freq_eeprom_o(f_ee), .torque_value_volatile_o(t_vol),
        .torque_value_persistent_o(t_per), .instr_start_o(start),
        .instr_code_o(i_code), .instr_data_o(i_data), .link_ext_param_o(ext_par));
    fb_master fb_master_inst (
        .clock_flags_i(flags), .clock_i(clock_i), .cmd_o(cmd), .req_o(req));

    // Core answers each code at once and each instruction after ack_wait cycles
    assign mon_val = {8'hc3, mon_code};
    initial
    begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    always @(posedge clock_i)
    begin
        if (start === 1'b1)
        begin
            repeat (ack_wait) @(posedge clock_i);
            ack <= 1'b1;
            @(posedge clock_i);
            ack <= 1'b0;
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic go(input int idx, input inv_link_pkg::link_cmd_s c, output int lat);
        logic ok;
        fb_master_inst.request(idx, c, lat, ok);
        chk({15'h0000, ok}, 16'h0001, "handshake");
        if (!ok)
            end_of_test();
    endtask

    task automatic setup(input logic [15:0] e, input logic [7:0] t);
        @(posedge clock_i);
        ext <= e;
        tsrc <= t;
    endtask

    task automatic wr(input int idx, input logic [15:0] v, input int exp_lat);
        inv_link_pkg::link_cmd_s c;
        int lat;
        c = cmd;
        c.freq_or_torque = v;
        go(idx, c, lat);
        chk(16'(lat), 16'(exp_lat), "write latency");
    endtask

    task automatic t_reset();
        chk({12'h000, flags}, 16'h0000, "flags at reset");
        chk(f_ram | f_ee | t_vol | t_per, 16'h0000, "stores at reset");
        chk(res[0] | res[5], 16'h0000, "results at reset");
    endtask

    task automatic t_freq();
        setup(16'h0000, 8'h00);
        // Raise edge to flag seen: take, go, done pulse, flag register
        wr(2, 16'he678, 4);
        chk(f_ram, 16'he678, "ram freq");
        chk(f_ee, 16'h0000, "eeprom untouched");
        wr(1, 16'h0001, 4 + EE);
        chk(f_ram, 16'h0001, "ram freq 2");
        chk(f_ee, 16'h0001, "eeprom freq");
        chk(t_vol, 16'h0000, "torque untouched");
    endtask

    task automatic t_torque();
        logic [15:0] ex [6] = '{16'h0000, 16'h0001, 16'h000c, 16'h0000, 16'h0001, 16'h000c};
        logic [7:0]  ts [6] = '{8'h03, 8'h03, 8'h03, 8'h05, 8'h05, 8'h05};
        for (int i = 0; i < 6; i++)
        begin
            setup(ex[i], ts[i]);
            wr(2, 16'h0100 + 16'(i), 4);
            chk(t_vol, 16'h0100 + 16'(i), "torque ram");
            chk(f_ram, 16'h0001, "freq kept");
        end
        wr(1, 16'h0aaa, 4 + EE);
        chk(t_vol, 16'h0aaa, "torque ram copy");
        chk(t_per, 16'h0aaa, "torque eeprom copy");
        setup(16'h0002, 8'h03);
        wr(2, 16'h0777, 4);
        chk(f_ram, 16'h0777, "ext 2 is freq");
        setup(16'h0000, 8'h04);
        wr(2, 16'h0778, 4);
        chk(f_ram, 16'h0778, "source 4 is freq");
        chk(t_vol, 16'h0aaa, "torque kept");
    endtask

    task automatic instr(input logic [15:0] e, input logic [15:0] code,
                         input logic [15:0] data);
        inv_link_pkg::link_cmd_s c;
        int lat;
        setup(e, 8'h00);
        c = cmd;
        c.instr_code = code;
        c.instr_data = data;
        go(0, c, lat);
        chk({15'h0000, lat >= ack_wait + 4}, 16'h0001, "done before ack");
    endtask

    task automatic t_instr();
        ack_wait = 6;
        @(posedge clock_i);
        ack <= 1'b1;
        @(posedge clock_i);
        ack <= 1'b0;
        repeat (3) @(posedge clock_i);
        chk({15'h0000, flags.instr_done}, 16'h0000, "stray ack");
        instr(16'h0000, 16'h0200, 16'h0000);
        chk(i_code, 16'h0200, "full code");
        chk(i_data, 16'h0000, "zero data");
        chk({8'h00, ext_par}, 16'h0000, "ext kept");
        instr(16'h0005, 16'h3c7b, 16'h1234);
        chk(i_code, 16'h007b, "low code");
        chk({8'h00, ext_par}, 16'h003c, "ext byte");
        chk(i_data, 16'h1234, "operand");
    endtask

    task automatic t_monitor();
        inv_link_pkg::link_cmd_s c;
        int lat;
        c = cmd;
        c.mon_a = 16'h2211;
        c.mon_c = 16'h0033;
        c.mon_d = 16'h0044;
        c.mon_ef = 16'h6655;
        go(3, c, lat);
        chk({15'h0000, lat <= 12}, 16'h0001, "monitor latency");
        chk(res[0], 16'hc311, "result 0");
        chk(res[1], 16'hc322, "result 1");
        for (int i = 2; i < 6; i++)
            chk(res[i], {8'hc3, 8'(8'h11 * (i + 1))}, "result 4..7");
    endtask

    initial
    begin
        nrst_i = 1'b0;
        ack = 1'b0;
        ext = 16'h0000;
        tsrc = 8'h00;
        ack_wait = 0;
        miscompares = 0;
        num_checks = 0;
        repeat (16) @(posedge clock_i);
        t_reset();
        nrst_i <= 1'b1;
        t_freq();
        t_torque();
        t_instr();
        t_monitor();
        end_of_test();
    end
endmodule
